/* File: logic/rtc_defines.svh */
// Purpose: Register offsets, field positions and reset values of the calendar clock.
// Assumes: Included by its bare name from the core, the checker and the bench.
// Notes: Definitions only.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// Register offsets on the 5-bit register port.
`define RTC_OFS_SEC 5'h00
`define RTC_OFS_MIN 5'h01
`define RTC_OFS_HOUR 5'h02
`define RTC_OFS_WDAY 5'h03
`define RTC_OFS_DATE 5'h04
`define RTC_OFS_MONTH 5'h05
`define RTC_OFS_YEAR 5'h06
`define RTC_OFS_CTRL 5'h07
`define RTC_OFS_ALM_SEC 5'h08
`define RTC_OFS_ALM_MIN 5'h09
`define RTC_OFS_ALM_HOUR 5'h0a
`define RTC_OFS_ALM_DATE 5'h0b
`define RTC_OFS_ALM_MONTH 5'h0c
`define RTC_OFS_ALM_MASK 5'h0d
`define RTC_OFS_WUT_LO 5'h0e
`define RTC_OFS_WUT_HI 5'h0f
`define RTC_OFS_STATUS 5'h10
`define RTC_OFS_IRQ_MASK 5'h11
`define RTC_OFS_PRE_LO 5'h12
`define RTC_OFS_PRE_HI 5'h13

// Control register fields.
`define RTC_CTRL_FMT12 0
`define RTC_CTRL_SRC_LO 1
`define RTC_CTRL_SRC_HI 2
`define RTC_CTRL_WSEL_LO 3
`define RTC_CTRL_WSEL_HI 5
`define RTC_CTRL_WUT_EN 6
`define RTC_CTRL_ALM_EN 7

// Hour field: bit 6 marks afternoon in twelve-hour format.
`define RTC_HOUR_PM 6

// Status and interrupt mask bits.
`define RTC_ST_ALARM 0
`define RTC_ST_WAKE 1

// Reset values.
`define RTC_RST_PRE 16'h7fff
`define RTC_RST_WUT 16'hffff
`define RTC_RST_TIME 8'h00
`define RTC_RST_DAY 8'h01
`define RTC_RST_CTRL 8'h00

`endif

/* File: logic/rtc_pkg.sv */
// Purpose: Types shared by the calendar clock modules.
// Assumes: The 5-bit address matches the offsets in rtc_defines.svh.
// Notes: Time fields are BCD bytes.
`default_nettype none

package rtc_pkg;

    // Current time and date, one BCD byte per field.
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] wday;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] sec;
    } rtc_time_t;

    // One register port request.
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtc_bus_req_t;

    // Wakeup tick resolution.
    typedef enum logic [2:0] {
        RTC_WU_DIV16,
        RTC_WU_DIV8,
        RTC_WU_DIV4,
        RTC_WU_DIV2,
        RTC_WU_SEC,
        RTC_WU_SEC_EXT
    } rtc_wu_sel_t;

endpackage

`default_nettype wire

/* File: logic/rtc_sync_edge.sv */
// Purpose: Brings one oscillator pin into ref_clk and marks its rising edges.
// Assumes: The pin toggles slower than half the ref_clk rate.
// Notes: The first stage feeds only the second.
`default_nettype none

module rtc_sync_edge (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Asynchronous pin.
    input wire logic pin,
    // One-cycle pulse per rising edge.
    output logic rise
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Two-stage synchroniser, then one more stage for the edge.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            rise <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            rise <= s2_reg & ~s3_reg;
        end
    end
endmodule // rtc_sync_edge

`default_nettype wire

/* File: logic/rtc_wakeup.sv */
// Purpose: Periodic wakeup down-counter.
// Assumes: tick is a one-cycle pulse at the chosen resolution.
// Notes: Expiry after reload plus one ticks.
`default_nettype none

module rtc_wakeup #(
    parameter int CW = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Control.
    input wire logic en,
    input wire logic ext,
    input wire logic [CW-1:0] reload,
    input wire logic tick,
    // Expiry pulse.
    output logic expire
);
    logic [CW:0] cnt_reg;
    logic [CW:0] load;

    if (CW < 2) begin : g_chk
        $error("rtc_wakeup: CW too small");
    end

    // The extension bit doubles the reach at the one-second resolution.
    assign load = {ext, reload};

    // Disabled counter holds its reload value so an enable starts a full period.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_reg <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (!en) begin
                cnt_reg <= load;
            end else if (tick) begin
                if (cnt_reg == '0) begin
                    expire <= 1'b1;
                    cnt_reg <= load;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end
endmodule // rtc_wakeup

`default_nettype wire

/* File: logic/rtc_core.sv */
// Purpose: BCD calendar clock with alarm, periodic wakeup and interrupt.
// Assumes: Oscillator pins are asynchronous to ref_clk (100 MHz) and slower than 50 MHz.
// Notes: Register port is 8 bits wide; read data stands one cycle after the strobe.
`default_nettype none
`include "rtc_defines.svh"

// Behaviour
// - Time and date are kept as BCD bytes for second, minute, hour, weekday, date, month, year.
// - Hours count in twelve- or twenty-four-hour format as software selects.
// - The date rolls at month end using 28, 29 in leap years, 30 or 31 days.
// - A programmable alarm and a periodic wakeup both raise interrupts that end sleep.
// - At the finest resolution of 61 us the wakeup interval spans 61 us to about 4 s.
// - A coarser one-second resolution stretches the wakeup interval up to 36 hours.
// - Alarms match calendar fields, repeating from every second to once a year.
// - Any of four oscillator sources may clock the calendar, independent of the system clock.
// - Counting never depends on CPU activity and the interrupt can end the sleep state.
module rtc_core #(
    parameter int PRE_W = 16,
    parameter int WUT_W = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Register port.
    input wire rtc_pkg::rtc_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // Oscillator pins.
    input wire logic [3:0] src_pin,
    // Calendar view and interrupt.
    output rtc_pkg::rtc_time_t time_now,
    output logic irq
);
    import rtc_pkg::*;

    if (PRE_W != 16 || WUT_W != 16) begin : g_chk
        $error("rtc_core: register map serves 16-bit prescaler and reload only");
    end

    rtc_time_t time_reg;
    rtc_time_t time_next;
    logic [7:0] ctrl_reg;
    logic [7:0] alm_sec_reg;
    logic [7:0] alm_min_reg;
    logic [7:0] alm_hour_reg;
    logic [7:0] alm_date_reg;
    logic [7:0] alm_month_reg;
    logic [7:0] alm_mask_reg;
    logic [WUT_W-1:0] wut_reg;
    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_cnt_reg;
    logic [3:0] div_cnt_reg;
    logic [1:0] status_reg;
    logic [1:0] irq_mask_reg;
    logic sec_tick_reg;
    logic sec_tick_d_reg;
    logic [3:0] src_rise;
    logic src_tick;
    logic wu_tick;
    logic wu_expire;
    logic alarm_hit;
    logic day_carry;
    logic leap;
    logic [7:0] month_len;
    logic [7:0] hr12;
    logic wr_hit;
    logic [4:0] addr;

    assign addr = bus_req.addr;
    assign wr_hit = bus_req.wr;

    // BCD increment of one byte; callers handle the wrap of each field.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = v + 8'h01;
        end
        return r;
    endfunction

    // Each oscillator pin is synchronised on its own so switching is glitch free.
    for (genvar i = 0; i < 4; i++) begin : g_src
        rtc_sync_edge u_sync (
            .ref_clk(ref_clk),
            .srst(srst),
            .pin(src_pin[i]),
            .rise(src_rise[i])
        );
    end

    // Selected source; the calendar never looks at the CPU clock tree.
    assign src_tick = src_rise[ctrl_reg[`RTC_CTRL_SRC_HI:`RTC_CTRL_SRC_LO]];

    // Prescaler to one second and the small binary divider for wakeup ticks.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pre_cnt_reg <= '0;
            div_cnt_reg <= 4'h0;
            sec_tick_reg <= 1'b0;
            sec_tick_d_reg <= 1'b0;
        end else begin
            sec_tick_reg <= 1'b0;
            sec_tick_d_reg <= sec_tick_reg;
            if (src_tick) begin
                div_cnt_reg <= div_cnt_reg + 4'h1;
                if (pre_cnt_reg >= pre_reg) begin
                    pre_cnt_reg <= '0;
                    sec_tick_reg <= 1'b1;
                end else begin
                    pre_cnt_reg <= pre_cnt_reg + 1'b1;
                end
            end
        end
    end

    // Wakeup resolution: source divided by 16, 8, 4 or 2, or whole seconds.
    always_comb begin
        wu_tick = 1'b0;
        unique case (rtc_wu_sel_t'(ctrl_reg[`RTC_CTRL_WSEL_HI:`RTC_CTRL_WSEL_LO]))
            RTC_WU_DIV16: wu_tick = src_tick && (div_cnt_reg == 4'hf);
            RTC_WU_DIV8: wu_tick = src_tick && (div_cnt_reg[2:0] == 3'h7);
            RTC_WU_DIV4: wu_tick = src_tick && (div_cnt_reg[1:0] == 2'h3);
            RTC_WU_DIV2: wu_tick = src_tick && div_cnt_reg[0];
            RTC_WU_SEC: wu_tick = sec_tick_reg;
            RTC_WU_SEC_EXT: wu_tick = sec_tick_reg;
            default: wu_tick = 1'b0;
        endcase
    end

    // Extension bit adds 65536 seconds so the interval reaches 36 hours.
    rtc_wakeup #(
        .CW(WUT_W)
    ) u_wakeup (
        .ref_clk(ref_clk),
        .srst(srst),
        .en(ctrl_reg[`RTC_CTRL_WUT_EN]),
        .ext(rtc_wu_sel_t'(ctrl_reg[`RTC_CTRL_WSEL_HI:`RTC_CTRL_WSEL_LO]) == RTC_WU_SEC_EXT),
        .reload(wut_reg),
        .tick(wu_tick),
        .expire(wu_expire)
    );

    // Leap year in BCD: tens even with units 0, 4, 8, or tens odd with 2, 6.
    always_comb begin
        leap = time_reg.year[4] ? (time_reg.year[3:0] == 4'h2 || time_reg.year[3:0] == 4'h6)
                                : (time_reg.year[3:0] == 4'h0 || time_reg.year[3:0] == 4'h4 ||
                                   time_reg.year[3:0] == 4'h8);
        unique case (time_reg.month)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    end

    // Next calendar value for one second step.
    always_comb begin
        time_next = time_reg;
        day_carry = 1'b0;
        hr12 = {2'b00, time_reg.hour[5:0]};
        time_next.sec = bcd_inc(time_reg.sec);
        if (time_reg.sec == 8'h59) begin
            time_next.sec = 8'h00;
            time_next.minute = bcd_inc(time_reg.minute);
            if (time_reg.minute == 8'h59) begin
                time_next.minute = 8'h00;
                if (ctrl_reg[`RTC_CTRL_FMT12]) begin
                    // Twelve-hour: 11 to 12 flips the half, 12 wraps to 01.
                    if (hr12 == 8'h12) begin
                        time_next.hour = {1'b0, time_reg.hour[`RTC_HOUR_PM], 6'h01};
                    end else if (hr12 == 8'h11) begin
                        time_next.hour = {1'b0, ~time_reg.hour[`RTC_HOUR_PM], 6'h12};
                        day_carry = time_reg.hour[`RTC_HOUR_PM];
                    end else begin
                        time_next.hour = bcd_inc(time_reg.hour);
                    end
                end else if (time_reg.hour == 8'h23) begin
                    time_next.hour = 8'h00;
                    day_carry = 1'b1;
                end else begin
                    time_next.hour = bcd_inc(time_reg.hour);
                end
            end
        end
        if (day_carry) begin
            time_next.wday = (time_reg.wday == 8'h07) ? 8'h01 : bcd_inc(time_reg.wday);
            if (time_reg.date == month_len) begin
                time_next.date = 8'h01;
                if (time_reg.month == 8'h12) begin
                    time_next.month = 8'h01;
                    time_next.year = (time_reg.year == 8'h99) ? 8'h00 : bcd_inc(time_reg.year);
                end else begin
                    time_next.month = bcd_inc(time_reg.month);
                end
            end else begin
                time_next.date = bcd_inc(time_reg.date);
            end
        end
    end

    // Calendar register; a software write to a field wins over the step.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            time_reg.sec <= `RTC_RST_TIME;
            time_reg.minute <= `RTC_RST_TIME;
            time_reg.hour <= `RTC_RST_TIME;
            time_reg.wday <= `RTC_RST_DAY;
            time_reg.date <= `RTC_RST_DAY;
            time_reg.month <= `RTC_RST_DAY;
            time_reg.year <= `RTC_RST_TIME;
        end else begin
            if (sec_tick_reg) begin
                time_reg <= time_next;
            end
            if (wr_hit) begin
                unique case (addr)
                    `RTC_OFS_SEC: time_reg.sec <= bus_req.wdata;
                    `RTC_OFS_MIN: time_reg.minute <= bus_req.wdata;
                    `RTC_OFS_HOUR: time_reg.hour <= bus_req.wdata;
                    `RTC_OFS_WDAY: time_reg.wday <= bus_req.wdata;
                    `RTC_OFS_DATE: time_reg.date <= bus_req.wdata;
                    `RTC_OFS_MONTH: time_reg.month <= bus_req.wdata;
                    `RTC_OFS_YEAR: time_reg.year <= bus_req.wdata;
                    default: ;
                endcase
            end
        end
    end

    assign time_now = time_reg;

    // Configuration registers.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_reg <= `RTC_RST_CTRL;
            alm_sec_reg <= `RTC_RST_TIME;
            alm_min_reg <= `RTC_RST_TIME;
            alm_hour_reg <= `RTC_RST_TIME;
            alm_date_reg <= `RTC_RST_DAY;
            alm_month_reg <= `RTC_RST_DAY;
            alm_mask_reg <= 8'h00;
            wut_reg <= `RTC_RST_WUT;
            pre_reg <= `RTC_RST_PRE;
            irq_mask_reg <= 2'b00;
        end else if (wr_hit) begin
            unique case (addr)
                `RTC_OFS_CTRL: ctrl_reg <= bus_req.wdata;
                `RTC_OFS_ALM_SEC: alm_sec_reg <= bus_req.wdata;
                `RTC_OFS_ALM_MIN: alm_min_reg <= bus_req.wdata;
                `RTC_OFS_ALM_HOUR: alm_hour_reg <= bus_req.wdata;
                `RTC_OFS_ALM_DATE: alm_date_reg <= bus_req.wdata;
                `RTC_OFS_ALM_MONTH: alm_month_reg <= bus_req.wdata;
                `RTC_OFS_ALM_MASK: alm_mask_reg <= bus_req.wdata;
                `RTC_OFS_WUT_LO: wut_reg[7:0] <= bus_req.wdata;
                `RTC_OFS_WUT_HI: wut_reg[15:8] <= bus_req.wdata;
                `RTC_OFS_PRE_LO: pre_reg[7:0] <= bus_req.wdata;
                `RTC_OFS_PRE_HI: pre_reg[15:8] <= bus_req.wdata;
                `RTC_OFS_IRQ_MASK: irq_mask_reg <= bus_req.wdata[1:0];
                default: ;
            endcase
        end
    end

    // Alarm compares one cycle after the step so the new time is seen.
    // A set mask bit ignores that field: all five masked fires every second,
    // none masked fires once a year.
    assign alarm_hit = ctrl_reg[`RTC_CTRL_ALM_EN] && sec_tick_d_reg &&
                       (alm_mask_reg[0] || time_reg.sec == alm_sec_reg) &&
                       (alm_mask_reg[1] || time_reg.minute == alm_min_reg) &&
                       (alm_mask_reg[2] || time_reg.hour == alm_hour_reg) &&
                       (alm_mask_reg[3] || time_reg.date == alm_date_reg) &&
                       (alm_mask_reg[4] || time_reg.month == alm_month_reg);

    // Sticky status; an event in the clearing read's cycle is kept.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status_reg <= 2'b00;
        end else begin
            status_reg <= ((bus_req.rd && addr == `RTC_OFS_STATUS) ? 2'b00 : status_reg) |
                          {wu_expire, alarm_hit};
        end
    end

    // Level interrupt; it runs without any CPU clock so it can end sleep.
    assign irq = |(status_reg & irq_mask_reg);

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (addr)
                `RTC_OFS_SEC: rd_data <= time_reg.sec;
                `RTC_OFS_MIN: rd_data <= time_reg.minute;
                `RTC_OFS_HOUR: rd_data <= time_reg.hour;
                `RTC_OFS_WDAY: rd_data <= time_reg.wday;
                `RTC_OFS_DATE: rd_data <= time_reg.date;
                `RTC_OFS_MONTH: rd_data <= time_reg.month;
                `RTC_OFS_YEAR: rd_data <= time_reg.year;
                `RTC_OFS_CTRL: rd_data <= ctrl_reg;
                `RTC_OFS_ALM_SEC: rd_data <= alm_sec_reg;
                `RTC_OFS_ALM_MIN: rd_data <= alm_min_reg;
                `RTC_OFS_ALM_HOUR: rd_data <= alm_hour_reg;
                `RTC_OFS_ALM_DATE: rd_data <= alm_date_reg;
                `RTC_OFS_ALM_MONTH: rd_data <= alm_month_reg;
                `RTC_OFS_ALM_MASK: rd_data <= alm_mask_reg;
                `RTC_OFS_WUT_LO: rd_data <= wut_reg[7:0];
                `RTC_OFS_WUT_HI: rd_data <= wut_reg[15:8];
                `RTC_OFS_STATUS: rd_data <= {6'h00, status_reg};
                `RTC_OFS_IRQ_MASK: rd_data <= {6'h00, irq_mask_reg};
                `RTC_OFS_PRE_LO: rd_data <= pre_reg[7:0];
                `RTC_OFS_PRE_HI: rd_data <= pre_reg[15:8];
                default: rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule // rtc_core

`default_nettype wire

/* File: testbench/rtc_core_asserts.sv */
// Purpose: Port checker of the calendar core.
// Assumes: Time writes are valid BCD.
// Notes: Bound at the foot of this file.
`default_nettype none
`include "rtc_defines.svh"

module rtc_core_asserts
    import rtc_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Register port.
    input wire rtc_pkg::rtc_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    // Pins, calendar and interrupt.
    input wire logic [3:0] src_pin,
    input wire rtc_pkg::rtc_time_t time_now,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [3:0] pin_prev;
    logic [7:0] since_edge;
    logic [7:0] since_wr;

    // Saturating ages of the last pin rise and the last write.
    always_ff @(posedge ref_clk) begin
        pin_prev <= src_pin;
        if (srst) begin
            since_edge <= 8'h00;
            since_wr <= 8'h00;
        end else begin
            since_edge <= (|(src_pin & ~pin_prev)) ? 8'h00 : since_edge + 8'(since_edge != 8'hff);
            since_wr <= bus_req.wr ? 8'h00 : since_wr + 8'(since_wr != 8'hff);
        end
    end

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // BCD leap test: unit low bits 00 under even tens, 10 under odd.
    function automatic logic [7:0] day_next(input logic [7:0] d, m, y);
        logic [7:0] last;
        if (m == 8'h02)
            last = (y[1:0] == {y[4], 1'b0}) ? 8'h29 : 8'h28;
        else
            last = (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) ? 8'h30 : 8'h31;
        return (d == last) ? 8'h01 : bcd_inc(d);
    endfunction

    // A change made by counting, not by reset or write.
    sequence s_counted;
        !$past(srst) && !$past(bus_req.wr);
    endsequence
    sequence s_min_roll;
        $past(time_now.minute) == 8'h59 && time_now.minute == 8'h00;
    endsequence

    property p_rd_one_cycle;
        !$past(bus_req.rd) |-> rd_data == 8'h00;
    endproperty
    property p_sec_step;
        s_counted ##0 !$stable(time_now.sec) |-> time_now.sec ==
            (($past(time_now.sec) == 8'h59) ? 8'h00 : bcd_inc($past(time_now.sec)));
    endproperty
    property p_hour_carry;
        s_counted ##0 !$stable(time_now.hour) |-> s_min_roll;
    endproperty
    property p_date_len;
        s_counted ##0 !$stable(time_now.date) |-> time_now.date ==
            day_next($past(time_now.date), $past(time_now.month), $past(time_now.year));
    endproperty
    property p_wday_step;
        s_counted ##0 !$stable(time_now.wday) |-> !$stable(time_now.date) &&
            time_now.wday == (($past(time_now.wday) == 8'h07) ? 8'h01 : $past(time_now.wday) + 8'h01);
    endproperty
    property p_irq_rise;
        $rose(irq) |-> since_edge <= 8'd12 || since_wr <= 8'd4;
    endproperty
    property p_irq_fall;
        $fell(irq) && !$past(srst) |->
            $past(bus_req.wr) || ($past(bus_req.rd) && $past(bus_req.addr) == `RTC_OFS_STATUS);
    endproperty
    property p_quiet;
        since_edge > 8'd12 && since_wr > 8'd12 |-> $stable(time_now);
    endproperty

    a_rd_one_cycle: assert property (p_rd_one_cycle) else $error("stray read data");
    a_sec_step: assert property (p_sec_step) else $error("bad second step");
    a_hour_carry: assert property (p_hour_carry) else $error("stray hour step");
    a_date_len: assert property (p_date_len) else $error("bad date step");
    a_wday_step: assert property (p_wday_step) else $error("bad weekday step");
    a_irq_rise: assert property (p_irq_rise) else $error("stray irq rise");
    a_irq_fall: assert property (p_irq_fall) else $error("stray irq fall");
    a_quiet: assert property (p_quiet) else $error("calendar moved idle");
endmodule // rtc_core_asserts

bind rtc_core rtc_core_asserts rtc_core_asserts_i (.ref_clk(ref_clk), .srst(srst),
    .bus_req(bus_req), .rd_data(rd_data), .src_pin(src_pin), .time_now(time_now), .irq(irq));

`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench of the calendar core.
// Assumes: Prescaler 0: each source rise is a second.
// Notes: Pins are pulsed by hand, still in between.
`default_nettype none
`include "rtc_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rtc_pkg::*;

    // One calendar step: format, time before and one second later.
    typedef struct packed {
        logic fmt12;
        rtc_time_t start;
        rtc_time_t after;
    } rtc_roll_row_t;

    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    rtc_bus_req_t bus_req = '0;
    logic [3:0] src_pin = 4'h0;
    logic [7:0] rd_data;
    rtc_time_t time_now;
    logic irq;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int k;
    rtc_roll_row_t rows [12] = '{
        '{1'b0, 56'h23_0228_0723_5959, 56'h23_0301_0100_0000},
        '{1'b0, 56'h24_0228_0323_5959, 56'h24_0229_0400_0000},
        '{1'b0, 56'h24_0229_0423_5959, 56'h24_0301_0500_0000},
        '{1'b0, 56'h23_0430_0223_5959, 56'h23_0501_0300_0000},
        '{1'b0, 56'h23_0530_0223_5959, 56'h23_0531_0300_0000},
        '{1'b0, 56'h23_0131_0223_5959, 56'h23_0201_0300_0000},
        '{1'b0, 56'h99_1231_0623_5959, 56'h00_0101_0700_0000},
        '{1'b0, 56'h00_0228_0123_5959, 56'h00_0229_0200_0000},
        '{1'b0, 56'h23_0509_0209_0909, 56'h23_0509_0209_0910},
        '{1'b1, 56'h23_0509_0211_5959, 56'h23_0509_0252_0000},
        '{1'b1, 56'h23_0509_0251_5959, 56'h23_0510_0312_0000},
        '{1'b1, 56'h23_0509_0252_5959, 56'h23_0509_0241_0000}
    };

    rtc_core rtc_core_i (.ref_clk(ref_clk), .srst(srst),
        .bus_req(bus_req), .rd_data(rd_data), .src_pin(src_pin), .time_now(time_now), .irq(irq));

    // 100 MHz reference clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cycle ceiling, far above the sequence's need.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: %s got %h, want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_time(input rtc_time_t got, input rtc_time_t exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: time got %h, want %h", $time, got, exp);
        end
    endtask

    // One-cycle strobe; back-to-back calls leave a gap cycle.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= {a, d, 2'b10};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus_req <= {a, 8'h00, 2'b01};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        cmp_byte(rd_data, exp, "read");
    endtask

    task automatic set_time(input rtc_time_t t);
        for (int i = 0; i < 7; i++)
            wr(5'(i), t[8 * i +: 8]);
    endtask

    // One slow rise on a pin, then settle time for time, status and irq.
    task automatic osc_pulse(input int p);
        @(posedge ref_clk);
        src_pin[p] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        src_pin[p] <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask

    // Source rises to the next wakeup, then clear.
    task automatic wake_edges(output int n);
        n = 0;
        do begin
            osc_pulse(0);
            n++;
        end while (irq !== 1'b1 && n < 40);
        rd_chk(`RTC_OFS_STATUS, 8'h02);
    endtask

    // Reset values, calendar rows, sources, alarm, wakeup, mid-run reset.
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        cmp_time(time_now, 56'h00_0101_0100_0000);
        rd_chk(`RTC_OFS_CTRL, 8'h00);
        rd_chk(`RTC_OFS_PRE_HI, 8'h7f);
        rd_chk(`RTC_OFS_WUT_LO, 8'hff);
        rd_chk(`RTC_OFS_ALM_MONTH, 8'h01);
        rd_chk(`RTC_OFS_IRQ_MASK, 8'h00);
        wr(5'h1f, 8'ha5);
        rd_chk(5'h1f, 8'h00);
        wr(`RTC_OFS_PRE_LO, 8'h00);
        wr(`RTC_OFS_PRE_HI, 8'h00);
        foreach (rows[i]) begin
            wr(`RTC_OFS_CTRL, {7'h00, rows[i].fmt12});
            set_time(rows[i].start);
            osc_pulse(0);
            cmp_time(time_now, rows[i].after);
        end
        // Only the chosen pin moves the calendar.
        for (int s = 0; s < 4; s++) begin
            wr(`RTC_OFS_CTRL, {5'h00, 2'(s), 1'b0});
            wr(`RTC_OFS_SEC, 8'h00);
            osc_pulse((s + 1) % 4);
            cmp_byte(time_now.sec, 8'h00, "other pin");
            osc_pulse(s);
            cmp_byte(time_now.sec, 8'h01, "own pin");
        end
        // Seconds-only match; a status read drops the interrupt.
        wr(`RTC_OFS_ALM_SEC, 8'h05);
        wr(`RTC_OFS_ALM_MASK, 8'h1e);
        wr(`RTC_OFS_IRQ_MASK, 8'h01);
        wr(`RTC_OFS_CTRL, 8'h80);
        wr(`RTC_OFS_SEC, 8'h04);
        osc_pulse(0);
        cmp_byte({7'h00, irq}, 8'h01, "alarm irq");
        rd_chk(`RTC_OFS_STATUS, 8'h01);
        cmp_byte({7'h00, irq}, 8'h00, "irq after clear");
        osc_pulse(0);
        rd_chk(`RTC_OFS_STATUS, 8'h00);
        // Full new-year match, interrupt masked.
        wr(`RTC_OFS_ALM_SEC, 8'h00);
        wr(`RTC_OFS_ALM_MASK, 8'h00);
        wr(`RTC_OFS_IRQ_MASK, 8'h00);
        set_time(56'h23_1231_0723_5959);
        osc_pulse(0);
        cmp_byte({7'h00, irq}, 8'h00, "masked irq");
        rd_chk(`RTC_OFS_STATUS, 8'h01);
        // Reload 2 at 1 s: every third tick expires.
        wr(`RTC_OFS_IRQ_MASK, 8'h02);
        wr(`RTC_OFS_WUT_LO, 8'h02);
        wr(`RTC_OFS_WUT_HI, 8'h00);
        wr(`RTC_OFS_CTRL, 8'h60);
        for (int r = 0; r < 2; r++) begin
            repeat (2) osc_pulse(0);
            rd_chk(`RTC_OFS_STATUS, 8'h00);
            osc_pulse(0);
            cmp_byte({7'h00, irq}, 8'h01, "wakeup irq");
            rd_chk(`RTC_OFS_STATUS, 8'h02);
        end
        // Divided ticks, first expiry aligning the phase; then the extended second.
        wr(`RTC_OFS_WUT_LO, 8'h00);
        for (int w = 0; w < 4; w++) begin
            wr(`RTC_OFS_CTRL, {2'b01, 3'(w), 3'h0});
            wake_edges(k);
            wake_edges(k);
            cmp_byte(8'(k), 8'(16 >> w), "edges");
        end
        wr(`RTC_OFS_CTRL, 8'h28);
        wr(`RTC_OFS_CTRL, 8'h68);
        osc_pulse(0);
        rd_chk(`RTC_OFS_STATUS, 8'h00);
        // Mid-run reset restores the calendar start.
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        cmp_time(time_now, 56'h00_0101_0100_0000);
        rd_chk(`RTC_OFS_CTRL, 8'h00);
        conclude();
    end
endmodule // tb

`default_nettype wire
